// >>> core/acp_pkg.sv
// Constants for the converter core power and ready register block.
// Assumes a single peripheral clock at 50 MHz and an APB register bus.
`default_nettype none
package acp_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] ACP_PWR_RDY_OFS = 12'h000;
  localparam logic [15:0] ACP_PWR_RDY_RST = 16'h0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ACP_SHR_RDY_BIT = 15;
  localparam int ACP_DED_RDY_LSB = 8;
  localparam int ACP_SHR_PWR_BIT = 7;
  localparam int ACP_DED_PWR_LSB = 0;
  localparam int ACP_NUM_DED     = 4;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int ACP_CLK_MHZ      = 50;
  localparam int ACP_WARMUP_NS    = 1000;
  localparam int ACP_WARMUP_CYC   = (ACP_WARMUP_NS * ACP_CLK_MHZ + 999) / 1000;

endpackage
`default_nettype wire

// >>> core/acp_warmup.sv
// One converter core power sequencer: counts warm-up after enable.
// Assumes enable comes from logic on the same clock.
`default_nettype none
`timescale 1ns/10ps
module acp_warmup
  import acp_pkg::*;
#(
  parameter int WARMUP_CYC = ACP_WARMUP_CYC
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control and status
  input  wire logic enable,
  output var  logic ready
);

  localparam int CW = $clog2(WARMUP_CYC + 1);

  initial begin
    if (WARMUP_CYC < 1) begin
      $error("warm-up count must be at least one cycle");
    end
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          ready_nxt;
  wire  logic    done = (cnt_r == CW'(WARMUP_CYC));

  // Clearing the enable drops ready at the next edge, no drain time
  assign cnt_nxt   = !enable ? '0 : (done ? cnt_r : cnt_r + CW'(1));
  assign ready_nxt = enable && done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      ready <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ready <= ready_nxt;
    end
  end

  ready_after_warm_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ready) |-> $past(enable, 1) && $past(done, 1))
    else $error("ready rose before warm-up finished");

  ready_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> !ready)
    else $error("ready stayed high after enable cleared");

endmodule
`default_nettype wire

// >>> core/acp_ctrl.sv
// Converter core power enable and ready status register, APB slave.
// Assumes a 32-bit APB master on pclk; ready comes from internal warm-up.
//
// How it works
// - shared core ready flag at bit 15
// - core 3 ready flag at bit 11
// - core 2 ready flag at bit 10
// - core 1 ready flag at bit 9
// - core 0 ready flag at bit 8
// - shared core power enable at bit 7
// - bits 14-12, 6-4 read zero, ignore writes
// - ready flags change only from hardware
`default_nettype none
`timescale 1ns/10ps
module acp_ctrl
  import acp_pkg::*;
#(
  parameter int WARMUP_CYC = ACP_WARMUP_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Power to converter cores
  output var  logic        shared_core_power_enable,
  output var  logic [3:0]  dedicated_core_power_enable
);

  initial begin
    if (WARMUP_CYC < 1) begin
      $error("warm-up count must be at least one cycle");
    end
  end

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Zero-wait slave: pready is high in every access phase.
  wire logic hit      = (paddr[11:2] == ACP_PWR_RDY_OFS[11:2]);
  wire logic setup    = psel && !penable;
  wire logic wr_ok    = setup && pwrite && hit && pstrb[0];
  wire logic bad      = setup && !hit;

  // ************************************************************
  // Enables
  // ************************************************************
  logic       shr_pwr_r;
  logic [3:0] ded_pwr_r;
  logic       shr_pwr_nxt;
  logic [3:0] ded_pwr_nxt;

  // Only byte lane 0 holds writable bits; the upper lane is status only
  assign shr_pwr_nxt = wr_ok ? pwdata[ACP_SHR_PWR_BIT] : shr_pwr_r;
  assign ded_pwr_nxt = wr_ok ? pwdata[ACP_DED_PWR_LSB +: ACP_NUM_DED] : ded_pwr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shr_pwr_r <= ACP_PWR_RDY_RST[ACP_SHR_PWR_BIT];
      ded_pwr_r <= ACP_PWR_RDY_RST[ACP_DED_PWR_LSB +: ACP_NUM_DED];
    end else begin
      shr_pwr_r <= shr_pwr_nxt;
      ded_pwr_r <= ded_pwr_nxt;
    end
  end

  // ************************************************************
  // Warm-up sequencers
  // ************************************************************
  wire logic [4:0] en_all = {shr_pwr_r, ded_pwr_r};
  logic      [4:0] rdy_all;

  for (genvar i = 0; i < 5; i++) begin : g_core
    acp_warmup #(
      .WARMUP_CYC (WARMUP_CYC)
    ) u_warm (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (en_all[i]),
      .ready   (rdy_all[i])
    );
  end

  // ************************************************************
  // Read image
  // ************************************************************
  logic [15:0] img;
  always_comb begin
    img = 16'h0000;
    img[ACP_SHR_RDY_BIT] = rdy_all[4];
    img[ACP_DED_RDY_LSB + 3] = rdy_all[3];
    img[ACP_DED_RDY_LSB + 2] = rdy_all[2];
    img[ACP_DED_RDY_LSB + 1] = rdy_all[1];
    img[ACP_DED_RDY_LSB]     = rdy_all[0];
    img[ACP_SHR_PWR_BIT] = shr_pwr_r;
    img[ACP_DED_PWR_LSB +: ACP_NUM_DED] = ded_pwr_r;
  end

  wire logic [31:0] rd_nxt = (setup && !pwrite && hit) ? {16'h0000, img} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      shared_core_power_enable    <= 1'b0;
      dedicated_core_power_enable <= 4'h0;
    end else begin
      prdata  <= rd_nxt;
      pready  <= setup;
      pslverr <= bad;
      shared_core_power_enable    <= shr_pwr_nxt;
      dedicated_core_power_enable <= ded_pwr_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  shr_rdy_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit) |=> prdata[15] == $past(rdy_all[4]))
    else $error("shared ready bit wrong on read");

  c3_rdy_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit) |=> prdata[11] == $past(rdy_all[3]))
    else $error("core 3 ready bit wrong");

  c2_rdy_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit) |=> prdata[10] == $past(rdy_all[2]))
    else $error("core 2 ready bit wrong");

  c1_rdy_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit) |=> prdata[9] == $past(rdy_all[1]))
    else $error("core 1 ready bit wrong");

  c0_rdy_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit) |=> prdata[8] == $past(rdy_all[0]))
    else $error("core 0 ready bit wrong");

  shr_pwr_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok |=> shared_core_power_enable == $past(pwdata[7]))
    else $error("shared power enable not written");

  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[14:12] == 3'h0 && prdata[6:4] == 3'h0)
    else $error("reserved bits not zero");

  ded_pwr_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok |=> dedicated_core_power_enable == $past(pwdata[3:0]))
    else $error("dedicated power enables not written");

  rdy_hw_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rdy_all[4]) |-> $past(shr_pwr_r, 1) ##0 $past(shr_pwr_r, 2))
    else $error("shared ready rose without power");

  rdy_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !shr_pwr_r |=> !rdy_all[4])
    else $error("shared ready held after power off");

  // ************************************************************
  // Bus handshake and per-core checks
  // ************************************************************
  // A broken handshake would hide every register fault behind it
  pready_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup
    |=> pready)
    else $error("no access phase answer after setup");

  pready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |=> !pready)
    else $error("pready held longer than one cycle");

  pready_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !psel
    |=> !pready)
    else $error("pready without a transfer");

  slverr_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr
    |-> pready)
    else $error("error flagged outside access phase");

  err_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !psel
    |=> !pslverr)
    else $error("error flagged without a transfer");

  good_no_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit)
    |=> !pslverr)
    else $error("error flagged on mapped address");

  idle_rdata_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready
    |-> prdata == 32'h0000_0000)
    else $error("read data outside access phase");

  upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  wr_rdata_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite)
    |=> prdata == 32'h0000_0000)
    else $error("read data on a write");

  unmapped_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    bad
    |=> prdata == 32'h0000_0000 && pslverr)
    else $error("unmapped access not refused");

  rsvd_img_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |-> img[14:12] == 3'h0 && img[6:4] == 3'h0)
    else $error("reserved image bits not zero");

  bad_no_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    bad
    |=> $stable(shr_pwr_r) && $stable(ded_pwr_r))
    else $error("unmapped write changed enables");

  strb_no_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite && hit && !pstrb[0])
    |=> $stable(shr_pwr_r) && $stable(ded_pwr_r))
    else $error("masked write changed enables");

  pwr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ok
    |=> $stable(shr_pwr_r) && $stable(ded_pwr_r))
    else $error("enables changed without a write");

  shr_out_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |-> shared_core_power_enable == shr_pwr_r)
    else $error("shared power pin differs from register");

  ded_out_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |-> dedicated_core_power_enable == ded_pwr_r)
    else $error("dedicated power pins differ from register");

  shr_pwr_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit)
    |=> prdata[7] == $past(shr_pwr_r))
    else $error("shared power bit wrong on read");

  ded_pwr_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit)
    |=> prdata[3:0] == $past(ded_pwr_r))
    else $error("dedicated power bits wrong on read");

  c3_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ded_pwr_r[3]
    |=> !rdy_all[3])
    else $error("core 3 ready held after power off");

  c2_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ded_pwr_r[2]
    |=> !rdy_all[2])
    else $error("core 2 ready held after power off");

  c1_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ded_pwr_r[1]
    |=> !rdy_all[1])
    else $error("core 1 ready held after power off");

  c0_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ded_pwr_r[0]
    |=> !rdy_all[0])
    else $error("core 0 ready held after power off");

  c3_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rdy_all[3])
    |-> $past(ded_pwr_r[3], 1) ##0 $past(ded_pwr_r[3], 2))
    else $error("core 3 ready rose without power");

  c2_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rdy_all[2])
    |-> $past(ded_pwr_r[2], 1) ##0 $past(ded_pwr_r[2], 2))
    else $error("core 2 ready rose without power");

  c1_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rdy_all[1])
    |-> $past(ded_pwr_r[1], 1) ##0 $past(ded_pwr_r[1], 2))
    else $error("core 1 ready rose without power");

  c0_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rdy_all[0])
    |-> $past(ded_pwr_r[0], 1) ##0 $past(ded_pwr_r[0], 2))
    else $error("core 0 ready rose without power");

endmodule
`default_nettype wire

// >>> bench/acp_core_model.sv
// Behavioural analog cores: flags each core warm once powered long enough.
// Assumes the power enables come from the register block on the same clock.
`timescale 1ns/10ps
`default_nettype none
module acp_core_model #(
  parameter int WARMUP_CYC = 3
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Power from the register block
  input  wire logic       shared_core_power_enable,
  input  wire logic [3:0] dedicated_core_power_enable,
  // Cores past warm-up
  output var  logic [4:0] warm
);
  logic [4:0] pwr;
  int         cnt [5];
  assign pwr = {shared_core_power_enable, dedicated_core_power_enable};
  // Losing power restarts warm-up at once
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 5; i++) begin
      if (!presetn || !pwr[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] <= WARMUP_CYC) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      warm[i] = cnt[i] > WARMUP_CYC;
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_adc_core_power_ready.sv
// Self-checking bench for the core power and ready register.
// Assumes the APB slave answers in its own time; every wait is bounded.
`timescale 1ns/10ps
`default_nettype none
module test_adc_core_power_ready;
  localparam int W = 3;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        shr_en, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, ded_en;
  logic [4:0]  warm;
  int          errors, check_count;
  acp_ctrl #(.WARMUP_CYC(W)) acp_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shared_core_power_enable(shr_en),
    .dedicated_core_power_enable(ded_en));
  acp_core_model #(.WARMUP_CYC(W)) acp_core_model_inst (.pclk(pclk),
    .presetn(presetn), .shared_core_power_enable(shr_en),
    .dedicated_core_power_enable(ded_en), .warm(warm));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int   n;
    logic ok;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ok = (pready === 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (!ok) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [31:0] exp, input string what);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check(what, rdat, exp);
    check("read error", {31'h0, rerr}, 32'h0);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_power_on();
    rd(32'h0, "reset image");
    apb(1'b1, 12'h000, 32'hffff_ffff, 4'h1);
    check("enables", {27'h0, shr_en, ded_en}, 32'h1f);
    rd(32'h8f, "early image");
    repeat (W + 4) @(posedge pclk);
    rd(32'h8f8f, "warm image");
    check("ready", {27'h0, rdat[15], rdat[11:8]}, {27'h0, warm});
    $display("test power on done");
  endtask
  task automatic test_refused();
    apb(1'b1, 12'h000, 32'h0, 4'h0);
    rd(32'h8f8f, "masked write");
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    check("slverr", {31'h0, rerr}, 32'h1);
    check("unmapped", rdat, 32'h0);
    $display("test refused done");
  endtask
  task automatic test_power_off();
    apb(1'b1, 12'h000, 32'h80, 4'h1);
    rd(32'h8080, "drop dedicated");
    apb(1'b1, 12'h000, 32'h0f, 4'h1);
    rd(32'h000f, "drop shared");
    $display("test power off done");
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_power_on();
    test_refused();
    test_power_off();
    complete_run();
  end
endmodule
`default_nettype wire
